// >>> design/pmwc_pkg.sv
// Package: register map, field positions, reset values and timing of the power/wake control block
package pmwc_pkg;
   localparam logic [7:0] PMWC_PMC_OFFSET = 8'h84;
   localparam logic [7:0] PMWC_BYTE_TEST_OFFSET = 8'h64;
   localparam int PMWC_READY_BIT = 0;
   localparam int PMWC_PIN_EN_BIT = 1;
   localparam int PMWC_POL_BIT = 2;
   localparam int PMWC_PULSE_BIT = 3;
   localparam int PMWC_CAUSE_LO = 4;
   localparam int PMWC_CAUSE_HI = 5;
   localparam int PMWC_TYPE_BIT = 6;
   localparam int PMWC_ENERGY_EVENT_ENABLE_BIT = 8;
   localparam int PMWC_WF_EN_BIT = 9;
   localparam int PMWC_PHY_RESET_REQUEST_BIT = 10;
   localparam int PMWC_MODE_LO = 12;
   localparam int PMWC_MODE_HI = 13;
   localparam logic [1:0] PMWC_MODE_NORMAL = 2'h0;
   localparam logic [1:0] PMWC_MODE_WAKE_FRAME = 2'h1;
   localparam logic [1:0] PMWC_MODE_ENERGY = 2'h2;
   localparam logic [1:0] PMWC_MODE_RESET_VAL = 2'h0;
   localparam int PMWC_CLK_HZ = 20000000;
   localparam int PMWC_PHY_RESET_REQUEST_US = 100;
   localparam int PMWC_PHY_RESET_REQUEST_CYC = (PMWC_PHY_RESET_REQUEST_US * (PMWC_CLK_HZ / 1000000));
   localparam int PMWC_PULSE_MS = 50;
   localparam int PMWC_PULSE_CYC = PMWC_PULSE_MS * (PMWC_CLK_HZ / 1000);
   localparam int PMWC_SETTLE_CYC = 16;
   typedef enum logic [2:0] {
      PMWC_ST_AWAKE = 3'b001,
      PMWC_ST_ASLEEP = 3'b010,
      PMWC_ST_SETTLE = 3'b100
   } pmwc_state_t;
endpackage : pmwc_pkg

// >>> design/pmwc_power_wake.sv
// Power management control: power states, wake-up, PHY reset pulse and wake pin
`timescale 1ns/10ps
module pmwc_power_wake #(
   parameter int PHY_RESET_REQUEST_CYC = pmwc_pkg::PMWC_PHY_RESET_REQUEST_CYC,
   parameter int PULSE_CYC = pmwc_pkg::PMWC_PULSE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register access
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Wake events
   input wire logic wake_frame_event,
   input wire logic energy_event,
   // Outputs
   output logic phy_reset,
   output logic [1:0] power_state,
   output logic device_ready,
   output logic writes_enabled,
   output logic wake_interrupt_flag,
   output logic wake_event_pin_o,
   output logic wake_event_pin_oe
);
   ///////////////////////////////////////////////////////////////////////////
   // State, configuration and counters
   pmwc_pkg::pmwc_state_t state_ff, nxt_state;
   logic [1:0] mode_ff;
   logic phy_reset_request_ff;
   logic [31:0] phy_cnt_ff;
   logic wf_en_ff, energy_event_enable_ff, type_ff, pulse_ff, pol_ff, pin_en_ff;
   logic [1:0] cause_ff;
   logic rd_seen_ff;
   logic [4:0] settle_ff;
   logic [31:0] pulse_cnt_ff;
   logic active_ff;
   logic [31:0] rdata_ff;

   // Address decode; PMC writes need a prior read and an awake device
   wire pmc_hit = reg_addr == pmwc_pkg::PMWC_PMC_OFFSET;
   wire bt_hit = reg_addr == pmwc_pkg::PMWC_BYTE_TEST_OFFSET;
   wire ready = state_ff == pmwc_pkg::PMWC_ST_AWAKE;
   wire wake_req = reg_wr && bt_hit && state_ff == pmwc_pkg::PMWC_ST_ASLEEP;
   wire pmc_wr = reg_wr && pmc_hit && rd_seen_ff && ready;
   // Reserved mode 11 is not a sleep request
   wire enter_sleep = pmc_wr && (reg_wdata[pmwc_pkg::PMWC_MODE_HI:pmwc_pkg::PMWC_MODE_LO] ==
      pmwc_pkg::PMWC_MODE_WAKE_FRAME || reg_wdata[pmwc_pkg::PMWC_MODE_HI:pmwc_pkg::PMWC_MODE_LO] ==
      pmwc_pkg::PMWC_MODE_ENERGY);
   // Sticky cause bits; an event beats a clear in the same cycle
   wire wf_hit = wake_frame_event && wf_en_ff;
   wire ed_hit = energy_event && energy_event_enable_ff;
   wire cause_clr_wf = pmc_wr && reg_wdata[pmwc_pkg::PMWC_CAUSE_HI];
   wire cause_clr_ed = pmc_wr && reg_wdata[pmwc_pkg::PMWC_CAUSE_LO];
   wire [1:0] nxt_cause = {wf_hit | (cause_ff[1] & ~cause_clr_wf),
      ed_hit | (cause_ff[0] & ~cause_clr_ed)};
   wire event_pending = |cause_ff;
   // Pin enable gates the pin only, never the flag
   wire pin_src = pin_en_ff && ((cause_ff[1] && wf_en_ff) || (cause_ff[0] && energy_event_enable_ff));
   // Pulse mode drops the pin once the timer runs out
   wire pulse_done = pulse_ff && pulse_cnt_ff >= 32'(PULSE_CYC);
   wire pin_active = pin_src && !pulse_done;
   // Read image; reserved positions read zero
   wire [31:0] pmc_value = {18'h0, mode_ff, 1'b0, phy_reset_request_ff, wf_en_ff, energy_event_enable_ff, 1'b0, type_ff,
      cause_ff, pulse_ff, pol_ff, pin_en_ff, ready};
   // Last cycle of the PHY reset hold
   wire phy_done = phy_reset_request_ff && phy_cnt_ff >= 32'(PHY_RESET_REQUEST_CYC - 1);

   ///////////////////////////////////////////////////////////////////////////
   // Sleep, wake and settle sequencing
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         pmwc_pkg::PMWC_ST_AWAKE: begin
            if (enter_sleep) begin
               nxt_state = pmwc_pkg::PMWC_ST_ASLEEP;
            end
         end
         pmwc_pkg::PMWC_ST_ASLEEP: begin
            if (wake_req) begin
               nxt_state = pmwc_pkg::PMWC_ST_SETTLE;
            end
         end
         pmwc_pkg::PMWC_ST_SETTLE: begin
            if (settle_ff == 5'(pmwc_pkg::PMWC_SETTLE_CYC - 1)) begin
               nxt_state = pmwc_pkg::PMWC_ST_AWAKE;
            end
         end
         default: nxt_state = pmwc_pkg::PMWC_ST_AWAKE;
      endcase
   end

   // Settle counter runs only while settling
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_ff <= pmwc_pkg::PMWC_ST_AWAKE;
         settle_ff <= 5'h0;
      end else begin
         state_ff <= nxt_state;
         settle_ff <= (state_ff == pmwc_pkg::PMWC_ST_SETTLE) ? settle_ff + 5'h1 : 5'h0;
      end
   end

   // Mode field, self-clearing on wake
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mode_ff <= pmwc_pkg::PMWC_MODE_RESET_VAL;
      end else if (enter_sleep) begin
         mode_ff <= reg_wdata[pmwc_pkg::PMWC_MODE_HI:pmwc_pkg::PMWC_MODE_LO];
      end else if (wake_req) begin
         mode_ff <= pmwc_pkg::PMWC_MODE_NORMAL;
      end
   end

   // First-read gate, re-armed by sleep entry and by wake
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_seen_ff <= 1'b0;
      end else if (wake_req || enter_sleep) begin
         rd_seen_ff <= 1'b0;
      end else if (reg_rd && ready) begin
         rd_seen_ff <= 1'b1;
      end
   end

   // Configuration bits
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wf_en_ff <= 1'b0;
         energy_event_enable_ff <= 1'b0;
         type_ff <= 1'b0;
         pulse_ff <= 1'b0;
         pol_ff <= 1'b0;
         pin_en_ff <= 1'b0;
      end else if (pmc_wr) begin
         wf_en_ff <= reg_wdata[pmwc_pkg::PMWC_WF_EN_BIT];
         energy_event_enable_ff <= reg_wdata[pmwc_pkg::PMWC_ENERGY_EVENT_ENABLE_BIT];
         type_ff <= reg_wdata[pmwc_pkg::PMWC_TYPE_BIT];
         pulse_ff <= reg_wdata[pmwc_pkg::PMWC_PULSE_BIT];
         pol_ff <= reg_wdata[pmwc_pkg::PMWC_POL_BIT];
         pin_en_ff <= reg_wdata[pmwc_pkg::PMWC_PIN_EN_BIT];
      end
   end

   // PHY reset pulse
   always_ff @(posedge clk) begin
      if (!nrst) begin
         phy_reset_request_ff <= 1'b0;
         phy_cnt_ff <= 32'h0;
      end else if (phy_reset_request_ff) begin
         // Host writes to the bit are ignored while the hold runs
         phy_cnt_ff <= phy_cnt_ff + 32'h1;
         if (phy_done) begin
            phy_reset_request_ff <= 1'b0;
         end
      end else if (pmc_wr && reg_wdata[pmwc_pkg::PMWC_PHY_RESET_REQUEST_BIT]) begin
         phy_reset_request_ff <= 1'b1;
         phy_cnt_ff <= 32'h0;
      end
   end

   // Wake cause and pin pulse timer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cause_ff <= 2'h0;
         pulse_cnt_ff <= 32'h0;
         active_ff <= 1'b0;
      end else begin
         cause_ff <= nxt_cause;
         active_ff <= pin_active;
         // Timer restarts with each new pin source
         if (!pin_src) begin
            pulse_cnt_ff <= 32'h0;
         end else if (!pulse_done) begin
            pulse_cnt_ff <= pulse_cnt_ff + 32'h1;
         end
      end
   end

   // Read data is registered; other addresses read zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_ff <= 32'h0;
      end else if (reg_rd) begin
         rdata_ff <= pmc_hit ? pmc_value : 32'h0;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Ports
   assign reg_rdata = rdata_ff;
   assign phy_reset = phy_reset_request_ff;
   assign power_state = mode_ff;
   assign device_ready = ready;
   assign writes_enabled = rd_seen_ff;
   assign wake_interrupt_flag = event_pending;
   // Open-drain: drive low only when active; push-pull: level per polarity
   assign wake_event_pin_oe = type_ff ? 1'b1 : active_ff;
   assign wake_event_pin_o = type_ff ? (pol_ff ? active_ff : ~active_ff) : 1'b0;
endmodule : pmwc_power_wake

// >>> tb/pmwc_power_wake_asserts.sv
// Checker: power and wake control port assertions
`timescale 1ns/10ps
module pmwc_power_wake_asserts #(parameter int PHY_RESET_REQUEST_CYC = 8, parameter int PULSE_CYC = 20) (
   input wire logic clk, nrst, reg_rd, reg_wr, phy_reset, device_ready, writes_enabled,
   input wire logic wake_interrupt_flag, wake_event_pin_o, wake_event_pin_oe,
   input wire logic [1:0] power_state, input wire logic [7:0] reg_addr, input wire logic [31:0] reg_wdata, reg_rdata);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire wr_ok = reg_wr && reg_addr == 8'h84 && writes_enabled && device_ready;
   wire phy_req = wr_ok && reg_wdata[10];
   AST_RSV_ZERO: assert property (reg_rd && reg_addr == 8'h84 |=> reg_rdata[31:14] == 18'h0 && !reg_rdata[11] && !reg_rdata[7]) else $error("rsv bits");
   AST_RD_STATE: assert property (reg_rd && reg_addr == 8'h84 |=> reg_rdata[13:12] == $past(power_state)) else $error("mode read");
   AST_PHY_HOLD: assert property ($rose(phy_reset) |-> phy_reset[*8] ##[1:4] !phy_reset) else $error("phy hold");
   AST_PHY_CAUSE: assert property ($rose(phy_reset) |-> $past(phy_req)) else $error("phy cause");
   AST_MODE_SET: assert property (wr_ok && ^reg_wdata[13:12] |=> power_state == $past(reg_wdata[13:12])) else $error("mode");
   AST_WAKE: assert property (|power_state && reg_wr && reg_addr == 8'h64 |=> power_state == 2'h0) else $error("wake");
   AST_SETTLE: assert property ($fell(|power_state) |-> !device_ready[*8] ##[1:40] device_ready) else $error("settle");
   AST_WR_GATE: assert property (reg_wr && reg_addr != 8'h64 && !writes_enabled |=> $stable(power_state) && !$rose(phy_reset)) else $error("gate");
endmodule : pmwc_power_wake_asserts
bind pmwc_power_wake pmwc_power_wake_asserts #(.PHY_RESET_REQUEST_CYC(PHY_RESET_REQUEST_CYC), .PULSE_CYC(PULSE_CYC)) u_chk (.clk, .nrst,
   .reg_rd, .reg_wr, .phy_reset, .device_ready, .writes_enabled, .wake_interrupt_flag, .wake_event_pin_o,
   .wake_event_pin_oe, .power_state, .reg_addr, .reg_wdata, .reg_rdata);

// >>> tb/pmwc_host_model.sv
// Host model: one strobe-bus transfer per call
`timescale 1ns/10ps
module pmwc_host_model (
   input wire logic clk, input wire logic [31:0] reg_rdata,
   output logic reg_rd = 1'b0, output logic reg_wr = 1'b0,
   output logic [7:0] reg_addr = 8'h0, output logic [31:0] reg_wdata = 32'h0);
   // Released address and data lines show inverted values; both strobes drop to 0
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      {reg_rd, reg_wr, reg_addr, reg_wdata} <= {!w, w, a, d};
      @(posedge clk);
      {reg_rd, reg_wr, reg_addr, reg_wdata} <= {2'h0, ~a, ~d};
      #1 q = reg_rdata;
   endtask : xfer
endmodule : pmwc_host_model

// >>> tb/test_power_mgmt_wake_control.sv
// Testbench: power and wake control block
`timescale 1ns/10ps
module test_power_mgmt_wake_control;
   logic clk = 1'b0, nrst = 1'b0, wake_frame_event = 1'b0, energy_event = 1'b0;
   logic reg_rd, reg_wr, phy_reset, device_ready, writes_enabled, wake_interrupt_flag, wake_event_pin_o, wake_event_pin_oe;
   logic [1:0] power_state;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v;
   int err_total = 0, checked = 0, n;
   wire pin = wake_event_pin_oe ? wake_event_pin_o : 1'b1;
   always #25 clk = ~clk;
   pmwc_power_wake #(.PHY_RESET_REQUEST_CYC(8), .PULSE_CYC(20)) dut (.clk, .nrst, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
      .reg_rdata, .wake_frame_event, .energy_event, .phy_reset, .power_state, .device_ready, .writes_enabled,
      .wake_interrupt_flag, .wake_event_pin_o, .wake_event_pin_oe);
   pmwc_host_model host (.clk, .reg_rdata, .reg_rd, .reg_wr, .reg_addr, .reg_wdata);
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("FAIL %0t got %h want %h", $time, s, e);
      end
   endtask : chk
   task wrap_up;
      $display("mismatches %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task wait_ready;
      n = 0;
      while (device_ready !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
      end
      if (n == 40) begin
         err_total++;
         wrap_up();
      end
   endtask : wait_ready
   task t_regs;
      host.xfer(1'b1, 8'h84, 32'h400, v);
      chk(32'({phy_reset, writes_enabled}), 32'h0);
      host.xfer(1'b0, 8'h20, 32'h0, v);
      chk(v, 32'h0);
      chk(32'(writes_enabled), 32'h1);
      host.xfer(1'b0, 8'h84, 32'h0, v);
      chk(v, 32'h1);
      host.xfer(1'b1, 8'h84, 32'hffffcbff, v);
      host.xfer(1'b0, 8'h84, 32'h0, v);
      chk(v, 32'h34f);
      host.xfer(1'b1, 8'h84, 32'h74e, v);
      host.xfer(1'b0, 8'h84, 32'h0, v);
      chk(v, 32'h74f);
      host.xfer(1'b1, 8'h84, 32'h74e, v);
      chk(32'(phy_reset), 32'h1);
      repeat (6) @(posedge clk);
      #1 chk(32'(phy_reset), 32'h0);
      host.xfer(1'b1, 8'h84, 32'h3000, v);
      chk(32'({power_state, device_ready}), 32'h1);
   endtask : t_regs
   task t_sleep(input logic [1:0] m);
      host.xfer(1'b1, 8'h84, {18'h0, m, 12'h0}, v);
      chk(32'({power_state, device_ready, writes_enabled}), 32'({m, 2'b00}));
      host.xfer(1'b0, 8'h84, 32'h0, v);
      chk(v, {18'h0, m, 12'h0});
      host.xfer(1'b1, 8'h64, 32'h5a5a5a5a, v);
      chk(32'(power_state), 32'h0);
      wait_ready();
      host.xfer(1'b1, 8'h84, 32'h400, v);
      chk(32'({phy_reset, writes_enabled}), 32'h0);
      host.xfer(1'b0, 8'h84, 32'h0, v);
      chk(v, 32'h1);
      chk(32'(writes_enabled), 32'h1);
   endtask : t_sleep
   task t_pin(input logic [31:0] c, input logic ed, input logic [2:0] e);
      host.xfer(1'b1, 8'h84, c, v);
      @(posedge clk);
      {wake_frame_event, energy_event} <= {!ed, ed};
      @(posedge clk);
      {wake_frame_event, energy_event} <= 2'h0;
      repeat (3) @(posedge clk);
      #1 chk(32'({pin, wake_interrupt_flag}), 32'(e[2:1]));
      repeat (25) @(posedge clk);
      #1 chk(32'(pin), 32'(e[0]));
      host.xfer(1'b1, 8'h84, c | 32'h30, v);
      chk(32'(wake_interrupt_flag), 32'h0);
   endtask : t_pin
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_sleep(2'h1);
      t_sleep(2'h2);
      t_pin(32'h206, 1'b0, 3'h2);
      t_pin(32'h146, 1'b1, 3'h7);
      t_pin(32'h14e, 1'b1, 3'h6);
      t_pin(32'h240, 1'b0, 3'h7);
      t_pin(32'h242, 1'b0, 3'h2);
      t_pin(32'h006, 1'b0, 3'h5);
      wrap_up();
   end
endmodule : test_power_mgmt_wake_control
